//--- bench/sensor_mode_sequencer_tb.sv
// Self-checking bench of the mode sequencer
`timescale 1ns/10ps
module sensor_mode_sequencer_tb;
  typedef struct {logic [2:0] t, p, h; logic g; logic [3:0] s;} smseq_row_s;
  logic clk_i, arst_n_i, psel, penable, pwrite, pready, pslverr, busy, heater_on;
  logic temp_conv, pres_conv, hum_conv, gas_conv, busy_q = 1'b0, order_bad = 1'b0;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q, r0, miscompares = 0, samples_checked = 0, rises = 0;
  logic [31:0] len [6] = '{default: 0};
  logic [7:0] heater_setpt, sp = 8'h00;
  logic [2:0] last_ph = 3'h0;
  logic e;
  logic [3:0] pi;
  smseq_row_s r;
  smseq_row_s rows [4] = '{'{3'h1, 3'h1, 3'h1, 1'b1, 4'h0}, '{3'h5, 3'h0, 3'h2, 1'b0, 4'h3},
                           '{3'h0, 3'h1, 3'h0, 1'b1, 4'h9}, '{3'h1, 3'h0, 3'h0, 1'b1, 4'hc}};
  smseq_top u_smseq_top (.clk_i(clk_i), .arst_n_i(arst_n_i), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .temp_conv_o(temp_conv), .pres_conv_o(pres_conv), .hum_conv_o(hum_conv),
    .gas_conv_o(gas_conv), .heater_on_o(heater_on), .heater_setpt_o(heater_setpt), .busy_o(busy));
  smseq_host u_smseq_host (.clk_i(clk_i), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  // ------------------------------------------------------------
  // Phase monitor: lengths, order, set-point, cycle starts
  // ------------------------------------------------------------
  always @(posedge clk_i) begin : mon
    logic [2:0] ph;
    logic first;
    ph = temp_conv ? 3'h1 : pres_conv ? 3'h2 : hum_conv ? 3'h3 : gas_conv ? 3'h5 :
         heater_on ? 3'h4 : 3'h0;
    first = busy && !busy_q;
    busy_q <= busy;
    // Cycle start clears the tallies; its own phase sample still counts
    if (first) begin
      rises <= rises + 1;
      last_ph <= 3'h0;
      sp <= 8'h00;
      for (int k = 1; k < 6; k++) len[k] <= 0;
    end
    if (ph != 3'h0) begin
      len[ph] <= first ? 32'h1 : len[ph] + 1;
      if (ph < last_ph && !first) order_bad <= 1'b1;
      last_ph <= ph;
      if (heater_on) sp <= heater_setpt;
    end
  end
  task end_of_test;
    if (miscompares == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task chk(input logic [31:0] s, input logic [31:0] x);
    samples_checked++;
    if (s !== x) begin
      miscompares++;
      $display("Error at %0t: seen %h expected %h", $time, s, x);
    end
  endtask
  task acc(input logic w, input logic [11:0] a, input logic [31:0] d);
    u_smseq_host.xfer(w, a, d, q, e);
    if (u_smseq_host.tmo) begin
      miscompares++;
      end_of_test();
    end
  endtask
  // Bounded wait for busy to reach a level
  task wait_lvl(input logic v);
    int n;
    n = 0;
    while (busy !== v && n < 3000) begin
      @(posedge clk_i);
      n++;
    end
    if (n >= 3000) begin
      miscompares++;
      end_of_test();
    end
  endtask
  function automatic logic [31:0] olen(input logic [2:0] v);
    return v == 3'h0 ? 32'h0 : 32'ha << (v - 3'h1);
  endfunction
  initial begin
    arst_n_i = 1'b0;
    repeat (20) @(posedge clk_i);
    chk(busy, 0);
    arst_n_i <= 1'b1;
    acc(0, 12'h00c, 0);
    chk(q, 0);
    acc(0, 12'h000, 0);
    chk(q, 0);
    for (int i = 0; i < 10; i++) acc(1, 12'h040 + 12'(4 * i), {16'h0, 8'(i + 1), 8'ha0 | 8'(i)});
    for (int i = 0; i < 4; i++) begin
      r = rows[i];
      pi = r.s > 4'h9 ? 4'h0 : r.s;
      acc(1, 12'h004, {21'h0, r.h, 1'b0, r.p, 1'b0, r.t});
      acc(1, 12'h008, {27'h0, r.g, r.s});
      acc(1, 12'h000, 32'h1);
      wait_lvl(1);
      wait_lvl(0);
      chk(len[1], olen(r.t));
      chk(len[2], olen(r.p));
      chk(len[3], olen(r.h));
      chk(len[4], r.g ? (pi + 1) * 10 : 0);
      chk(len[5], r.g ? 8 : 0);
      chk(sp, r.g ? {4'ha, pi} : 0);
      chk(order_bad, 0);
      acc(0, 12'h000, 0);
      chk(q[1:0], 0);
    end
    r0 = rises;
    acc(1, 12'h004, 32'h3);
    acc(1, 12'h000, 32'h1);
    wait_lvl(1);
    acc(1, 12'h000, 32'h1);
    acc(1, 12'h004, 32'h0);
    acc(0, 12'h00c, 0);
    chk(q[6], 1);
    chk(q[5], 1);
    wait_lvl(0);
    wait_lvl(1);
    wait_lvl(0);
    chk(rises, r0 + 2);
    chk(len[1], 40);
    foreach (rows[m]) begin
      acc(1, 12'h000, 32'(m & 2 ? m : 0));
      repeat (20) @(posedge clk_i);
    end
    chk(rises, r0 + 2);
    acc(0, 12'h010, 0);
    chk(e, 1);
    acc(0, 12'h004, 0);
    chk(q, 32'h3);
    chk(e, 0);
    // Reset in the middle of a cycle must land back in sleep
    acc(1, 12'h000, 32'h1);
    wait_lvl(1);
    arst_n_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    chk(busy, 0);
    arst_n_i <= 1'b1;
    acc(0, 12'h000, 0);
    chk(q, 0);
    acc(0, 12'h00c, 0);
    chk(q, 0);
    end_of_test();
  end
endmodule // sensor_mode_sequencer_tb

//--- bench/smseq_chk.sv
// Port checker of the mode sequencer
`timescale 1ns/10ps
module smseq_chk (
  input wire logic clk_i, // Clock
  input wire logic arst_n_i, // Reset, low
  input wire logic psel, // Select
  input wire logic penable, // Access
  input wire logic pwrite, // Write
  input wire logic [11:0] paddr, // Address
  input wire logic [31:0] pwdata, // Write data
  input wire logic [31:0] prdata, // Read data
  input wire logic pready, // Ready
  input wire logic pslverr, // Error
  input wire logic temp_conv_o, // Temp phase
  input wire logic pres_conv_o, // Pres phase
  input wire logic hum_conv_o, // Hum phase
  input wire logic gas_conv_o, // Gas phase
  input wire logic heater_on_o, // Heater
  input wire logic [7:0] heater_setpt_o, // Set-point
  input wire logic busy_o // Busy
);
  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  default clocking @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);
  logic conv; // Any conversion running
  assign conv = temp_conv_o | pres_conv_o | hum_conv_o | gas_conv_o;
  one_phase_a: assert property (
    $onehot0({temp_conv_o, pres_conv_o, hum_conv_o, gas_conv_o}))
    else $error("Two conversions at once");
  sleep_quiet_a: assert property (!busy_o |-> !conv && !heater_on_o)
    else $error("Activity outside a cycle");
  heat_gas_a: assert property (
    heater_on_o |-> !temp_conv_o && !pres_conv_o && !hum_conv_o)
    else $error("Heater on in a wrong phase");
  gas_heat_a: assert property (gas_conv_o |-> heater_on_o)
    else $error("Gas phase without heater");
  hum_order_a: assert property (hum_conv_o |=> !temp_conv_o && !pres_conv_o)
    else $error("Phase after humidity out of order");
  pres_order_a: assert property (pres_conv_o |=> !temp_conv_o)
    else $error("Temperature after pressure");
  gas_end_a: assert property ($fell(gas_conv_o) |-> ##[0:3] !busy_o)
    else $error("No return to sleep after gas");
  setpt_hold_a: assert property (
    heater_on_o && $past(heater_on_o) |-> $stable(heater_setpt_o))
    else $error("Set-point moved while heating");
  setpt_off_a: assert property (!heater_on_o |-> heater_setpt_o == 8'h00)
    else $error("Set-point shown with heater off");
  mode_start_a: assert property (psel && penable && pready && pwrite && paddr == 12'h000
    && pwdata[1:0] == 2'h1 && !busy_o |-> ##[1:5] busy_o) else $error("Forced cycle not started");
  apb_wait_a: assert property (psel && penable && !pready |=> pready)
    else $error("Access not answered");
  err_ready_a: assert property (pslverr |-> pready) else $error("Error without ready");
  gas_c: cover property (gas_conv_o);
  err_c: cover property (pslverr);
  end_c: cover property ($fell(busy_o));
endmodule // smseq_chk

bind smseq_top smseq_chk u_smseq_chk (.clk_i(clk_i), .arst_n_i(arst_n_i), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .temp_conv_o(temp_conv_o), .pres_conv_o(pres_conv_o),
  .hum_conv_o(hum_conv_o), .gas_conv_o(gas_conv_o), .heater_on_o(heater_on_o),
  .heater_setpt_o(heater_setpt_o), .busy_o(busy_o));

//--- bench/smseq_host.sv
// Host model: APB master that programs the sequencer
`timescale 1ns/10ps
module smseq_host (
  input wire logic clk_i, // Clock
  input wire logic [31:0] prdata, // Read data
  input wire logic pready, // Ready
  input wire logic pslverr, // Error
  output logic psel, // Select
  output logic penable, // Access
  output logic pwrite, // Write
  output logic [11:0] paddr, // Address
  output logic [31:0] pwdata // Write data
);
  logic tmo = 1'b0; // Set when a wait ran out
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
  end
  // One transfer; request held until ready is seen at an edge
  task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    int n;
    @(posedge clk_i);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_i);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) tmo = 1'b1;
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Released lines flip so stale values never look valid
    paddr <= ~a;
    pwdata <= ~d;
  endtask
endmodule // smseq_host

//--- core/smseq_cfg.svh
// Register offsets, field positions, reset values and timing counts of the sequencer
`ifndef SMSEQ_CFG_SVH
`define SMSEQ_CFG_SVH

// ------------------------------------------------------------
// Register byte offsets
// ------------------------------------------------------------
`define SMSEQ_OFF_CTRL 12'h000
`define SMSEQ_OFF_MEAS 12'h004
`define SMSEQ_OFF_GAS 12'h008
`define SMSEQ_OFF_STAT 12'h00c
`define SMSEQ_OFF_PROF_BASE 12'h040
`define SMSEQ_OFF_PROF_LAST 12'h064

// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define SMSEQ_MODE_LSB 0
`define SMSEQ_MODE_MSB 1
`define SMSEQ_OS_T_LSB 0
`define SMSEQ_OS_T_MSB 2
`define SMSEQ_OS_P_LSB 4
`define SMSEQ_OS_P_MSB 6
`define SMSEQ_OS_H_LSB 8
`define SMSEQ_OS_H_MSB 10
`define SMSEQ_PSEL_LSB 0
`define SMSEQ_PSEL_MSB 3
`define SMSEQ_GAS_EN_BIT 4
`define SMSEQ_SETPT_LSB 0
`define SMSEQ_SETPT_MSB 7
`define SMSEQ_DUR_LSB 8
`define SMSEQ_DUR_MSB 15

// ------------------------------------------------------------
// Reset values and codes
// ------------------------------------------------------------
`define SMSEQ_MODE_SLEEP 2'h0
`define SMSEQ_MODE_FORCED 2'h1
`define SMSEQ_OS_RST 3'h0
`define SMSEQ_PSEL_RST 4'h0
`define SMSEQ_PROF_RST 8'h00
`define SMSEQ_NUM_PROF 10

// ------------------------------------------------------------
// Timing: one oversample pass, and one heater duration unit
// ------------------------------------------------------------
`define SMSEQ_PASS_NS 100
`define SMSEQ_CLK_NS 10
`define SMSEQ_PASS_CYC ((`SMSEQ_PASS_NS + `SMSEQ_CLK_NS - 1) / `SMSEQ_CLK_NS)
`define SMSEQ_HEAT_UNIT_NS 100
`define SMSEQ_HEAT_UNIT_CYC ((`SMSEQ_HEAT_UNIT_NS + `SMSEQ_CLK_NS - 1) / `SMSEQ_CLK_NS)
`define SMSEQ_GAS_CONV_CYC 16'h0008

`endif

//--- core/smseq_phase_timer.sv
// Down counter that times one conversion or heating phase
`timescale 1ns/10ps
`include "smseq_cfg.svh"

module smseq_phase_timer (
  input wire logic clk_i, // System clock
  input wire logic arst_n_i, // Async reset, active low
  input wire logic load_i, // Load a new phase length
  input wire smseq_pkg::smseq_cnt_t len_i, // Phase length in cycles
  output logic done_o // Pulse at phase end
);

  smseq_pkg::smseq_cnt_t cnt_r; // Remaining cycles
  smseq_pkg::smseq_cnt_t cnt_nxt;
  logic run_r; // Phase running
  logic run_nxt;

  // ------------------------------------------------------------
  // Next-state logic
  // ------------------------------------------------------------
  always_comb begin
    cnt_nxt = cnt_r;
    run_nxt = run_r;
    if (load_i) begin
      // Zero length still takes one cycle, so no phase is lost
      cnt_nxt = (len_i == 16'h0000) ? 16'h0001 : len_i;
      run_nxt = 1'b1;
    end else if (run_r) begin
      if (cnt_r == 16'h0001) begin
        run_nxt = 1'b0;
      end
      cnt_nxt = cnt_r - 16'h0001;
    end
  end

  // Registers only
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cnt_r <= 16'h0000;
      run_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      run_r <= run_nxt;
    end
  end

  // Done in the last counted cycle, so a phase of length n lasts n cycles
  assign done_o = run_r && (cnt_r == 16'h0001);
endmodule // smseq_phase_timer

//--- core/smseq_pkg.sv
// Types shared by the sequencer files
package smseq_pkg;
  // Measurement sequencer states, one-hot
  typedef enum logic [5:0] {
    ST_SLEEP = 6'h01,
    ST_TEMP = 6'h02,
    ST_PRES = 6'h04,
    ST_HUM = 6'h08,
    ST_HEAT = 6'h10,
    ST_GAS = 6'h20
  } smseq_state_e;

  typedef logic [15:0] smseq_cnt_t; // Phase counter width
endpackage

//--- core/smseq_top.sv
// Operating-mode sequencer of a four-channel sensor with APB registers
//
// The placing of the registers and the APB interface to the registers are this design's own decisions.
`timescale 1ns/10ps
`include "smseq_cfg.svh"

module smseq_top (
  input wire logic clk_i, // System clock, 100 MHz
  input wire logic arst_n_i, // Async reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB access phase
  input wire logic pwrite, // APB write
  input wire logic [11:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error
  output logic temp_conv_o, // Temperature conversion active
  output logic pres_conv_o, // Pressure conversion active
  output logic hum_conv_o, // Humidity conversion active
  output logic gas_conv_o, // Gas conversion active
  output logic heater_on_o, // Hot-plate heater drive
  output logic [7:0] heater_setpt_o, // Heater set-point code
  output logic busy_o // Measurement cycle running
);

  // ------------------------------------------------------------
  // Control registers
  // ------------------------------------------------------------
  logic [1:0] mode_r; // Mode field as seen by software
  logic [1:0] mode_nxt;
  logic pend_r; // Mode change waiting
  logic pend_nxt;
  logic [2:0] os_t_r, os_p_r, os_h_r; // Oversampling settings
  logic [2:0] os_t_nxt, os_p_nxt, os_h_nxt;
  logic [3:0] psel_r; // heater_profile_select
  logic [3:0] psel_nxt;
  logic gas_en_r; // Gas enable
  logic gas_en_nxt;
  logic [7:0] setpt_r [0:`SMSEQ_NUM_PROF-1]; // Profile set-points
  logic [7:0] dur_r [0:`SMSEQ_NUM_PROF-1]; // Profile durations
  logic [7:0] setpt_nxt [0:`SMSEQ_NUM_PROF-1];
  logic [7:0] dur_nxt [0:`SMSEQ_NUM_PROF-1];

  // ------------------------------------------------------------
  // Sequencer state
  // ------------------------------------------------------------
  smseq_pkg::smseq_state_e st_r, st_nxt;
  logic load; // Start a timed phase
  smseq_pkg::smseq_cnt_t len; // Its length
  logic ph_done; // Timer done pulse
  logic [3:0] prof_idx; // Profile index, zero when out of range

  // Bus and out registers
  logic [31:0] prdata_nxt;
  logic pready_nxt, pslverr_nxt;
  logic [4:0] conv_nxt; // T,P,H,G,heater
  logic [7:0] heat_sp_nxt;

  // APB access phase strobes
  logic acc, wr, rd;
  assign acc = psel && penable && !pready;
  // Writes land at the edge that completes the transfer, with pready high
  assign wr = psel && penable && pready && pwrite;
  assign rd = acc && !pwrite;

  // Out-of-range select falls back to profile zero
  assign prof_idx = (psel_r < 4'(`SMSEQ_NUM_PROF)) ? psel_r : 4'h0;

  // Length of one conversion from its oversampling code
  function automatic smseq_pkg::smseq_cnt_t os_len(input logic [2:0] os);
    logic [4:0] passes;
    // Codes above sixteen-fold clamp there, so the count never wraps to zero
    passes = (os > 3'h5) ? 5'h10 : 5'h01 << (os - 3'h1);
    os_len = 16'(passes) * 16'(`SMSEQ_PASS_CYC);
  endfunction

  // ------------------------------------------------------------
  // Register write logic
  // ------------------------------------------------------------
  always_comb begin
    mode_nxt = mode_r;
    pend_nxt = pend_r;
    os_t_nxt = os_t_r;
    os_p_nxt = os_p_r;
    os_h_nxt = os_h_r;
    psel_nxt = psel_r;
    gas_en_nxt = gas_en_r;
    setpt_nxt = setpt_r;
    dur_nxt = dur_r;
    // Forced cycle over: mode reads sleep again, unless a held command waits
    if (st_r != smseq_pkg::ST_SLEEP && st_nxt == smseq_pkg::ST_SLEEP && !pend_r) begin
      mode_nxt = `SMSEQ_MODE_SLEEP;
    end
    // Pending change carried out once the sequencer sits in sleep
    if (pend_r && st_r == smseq_pkg::ST_SLEEP) begin
      pend_nxt = 1'b0;
    end
    // All control writes ignored while a change is pending
    if (wr && !pend_r) begin
      if (paddr == `SMSEQ_OFF_CTRL) begin
        mode_nxt = pwdata[`SMSEQ_MODE_MSB:`SMSEQ_MODE_LSB];
        // Held until the running cycle ends
        if (st_r != smseq_pkg::ST_SLEEP) begin
          pend_nxt = 1'b1;
        end
      end else if (paddr == `SMSEQ_OFF_MEAS) begin
        os_t_nxt = pwdata[`SMSEQ_OS_T_MSB:`SMSEQ_OS_T_LSB];
        os_p_nxt = pwdata[`SMSEQ_OS_P_MSB:`SMSEQ_OS_P_LSB];
        os_h_nxt = pwdata[`SMSEQ_OS_H_MSB:`SMSEQ_OS_H_LSB];
      end else if (paddr == `SMSEQ_OFF_GAS) begin
        psel_nxt = pwdata[`SMSEQ_PSEL_MSB:`SMSEQ_PSEL_LSB];
        gas_en_nxt = pwdata[`SMSEQ_GAS_EN_BIT];
      end
    end
    for (int i = 0; i < `SMSEQ_NUM_PROF; i++) begin
      if (wr && !pend_r && paddr == `SMSEQ_OFF_PROF_BASE + 12'(4 * i)) begin
        setpt_nxt[i] = pwdata[`SMSEQ_SETPT_MSB:`SMSEQ_SETPT_LSB];
        dur_nxt[i] = pwdata[`SMSEQ_DUR_MSB:`SMSEQ_DUR_LSB];
      end
    end
  end

  // ------------------------------------------------------------
  // Measurement sequencer
  // ------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    load = 1'b0;
    len = 16'h0000;
    case (st_r)
      smseq_pkg::ST_SLEEP: begin
        // Only mode 01 leaves sleep; 00 keeps everything idle
        if (!pend_r && mode_r == `SMSEQ_MODE_FORCED) begin
          st_nxt = smseq_pkg::ST_TEMP;
          load = 1'b1;
          len = (os_t_r == `SMSEQ_OS_RST) ? 16'h0001 : os_len(os_t_r);
        end
      end
      smseq_pkg::ST_TEMP: begin
        if (ph_done) begin
          st_nxt = smseq_pkg::ST_PRES;
          load = 1'b1;
          len = (os_p_r == `SMSEQ_OS_RST) ? 16'h0001 : os_len(os_p_r);
        end
      end
      smseq_pkg::ST_PRES: begin
        if (ph_done) begin
          st_nxt = smseq_pkg::ST_HUM;
          load = 1'b1;
          len = (os_h_r == `SMSEQ_OS_RST) ? 16'h0001 : os_len(os_h_r);
        end
      end
      smseq_pkg::ST_HUM: begin
        if (ph_done) begin
          if (gas_en_r) begin
            st_nxt = smseq_pkg::ST_HEAT;
            load = 1'b1;
            len = 16'(dur_r[prof_idx]) * 16'(`SMSEQ_HEAT_UNIT_CYC);
          end else begin
            st_nxt = smseq_pkg::ST_SLEEP;
          end
        end
      end
      smseq_pkg::ST_HEAT: begin
        if (ph_done) begin
          st_nxt = smseq_pkg::ST_GAS;
          load = 1'b1;
          len = `SMSEQ_GAS_CONV_CYC;
        end
      end
      smseq_pkg::ST_GAS: begin
        if (ph_done) begin
          st_nxt = smseq_pkg::ST_SLEEP;
        end
      end
      default: begin
        st_nxt = smseq_pkg::ST_SLEEP;
      end
    endcase
  end

  // One timer serves every phase; each phase loads it on entry
  smseq_phase_timer u_timer (
    .clk_i(clk_i),
    .arst_n_i(arst_n_i),
    .load_i(load),
    .len_i(len),
    .done_o(ph_done)
  );

  // ------------------------------------------------------------
  // Outputs and bus answer
  // ------------------------------------------------------------
  always_comb begin
    // Conversion strobes stay low for skipped channels
    conv_nxt[0] = (st_nxt == smseq_pkg::ST_TEMP) && (os_t_r != `SMSEQ_OS_RST);
    conv_nxt[1] = (st_nxt == smseq_pkg::ST_PRES) && (os_p_r != `SMSEQ_OS_RST);
    conv_nxt[2] = (st_nxt == smseq_pkg::ST_HUM) && (os_h_r != `SMSEQ_OS_RST);
    conv_nxt[3] = (st_nxt == smseq_pkg::ST_GAS);
    // Heater driven through the heat and gas phases
    conv_nxt[4] = (st_nxt == smseq_pkg::ST_HEAT) || (st_nxt == smseq_pkg::ST_GAS);
    heat_sp_nxt = conv_nxt[4] ? setpt_r[prof_idx] : 8'h00;
    pready_nxt = acc;
    pslverr_nxt = 1'b0;
    prdata_nxt = 32'h0000_0000;
    if (rd) begin
      if (paddr == `SMSEQ_OFF_CTRL) begin
        prdata_nxt = {30'h0, mode_r};
      end else if (paddr == `SMSEQ_OFF_MEAS) begin
        prdata_nxt = {21'h0, os_h_r, 1'b0, os_p_r, 1'b0, os_t_r};
      end else if (paddr == `SMSEQ_OFF_GAS) begin
        prdata_nxt = {27'h0, gas_en_r, psel_r};
      end else if (paddr == `SMSEQ_OFF_STAT) begin
        prdata_nxt = {24'h0, 1'b0, pend_r, st_r != smseq_pkg::ST_SLEEP, 5'(st_r >> 1)};
      end else if (paddr >= `SMSEQ_OFF_PROF_BASE && paddr <= `SMSEQ_OFF_PROF_LAST
                   && paddr[1:0] == 2'h0) begin
        prdata_nxt = {16'h0, dur_r[4'(paddr[5:2])], setpt_r[4'(paddr[5:2])]};
      end else begin
        pslverr_nxt = 1'b1; // Unmapped
      end
    end else if (acc && pwrite) begin
      if (!(paddr == `SMSEQ_OFF_CTRL || paddr == `SMSEQ_OFF_MEAS || paddr == `SMSEQ_OFF_GAS
            || (paddr >= `SMSEQ_OFF_PROF_BASE && paddr <= `SMSEQ_OFF_PROF_LAST
                && paddr[1:0] == 2'h0))) begin
        pslverr_nxt = 1'b1;
      end
    end
  end

  // All state registers; reset lands in sleep without any command
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      st_r <= smseq_pkg::ST_SLEEP;
      mode_r <= `SMSEQ_MODE_SLEEP;
      pend_r <= 1'b0;
      os_t_r <= `SMSEQ_OS_RST;
      os_p_r <= `SMSEQ_OS_RST;
      os_h_r <= `SMSEQ_OS_RST;
      psel_r <= `SMSEQ_PSEL_RST;
      gas_en_r <= 1'b0;
      for (int i = 0; i < `SMSEQ_NUM_PROF; i++) begin
        setpt_r[i] <= `SMSEQ_PROF_RST;
        dur_r[i] <= `SMSEQ_PROF_RST;
      end
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      {heater_on_o, gas_conv_o, hum_conv_o, pres_conv_o, temp_conv_o} <= 5'h00;
      heater_setpt_o <= 8'h00;
      busy_o <= 1'b0;
    end else begin
      st_r <= st_nxt;
      mode_r <= mode_nxt;
      pend_r <= pend_nxt;
      os_t_r <= os_t_nxt;
      os_p_r <= os_p_nxt;
      os_h_r <= os_h_nxt;
      psel_r <= psel_nxt;
      gas_en_r <= gas_en_nxt;
      setpt_r <= setpt_nxt;
      dur_r <= dur_nxt;
      prdata <= prdata_nxt;
      pready <= pready_nxt;
      pslverr <= pslverr_nxt;
      {heater_on_o, gas_conv_o, hum_conv_o, pres_conv_o, temp_conv_o} <= conv_nxt;
      heater_setpt_o <= heat_sp_nxt;
      busy_o <= (st_nxt != smseq_pkg::ST_SLEEP);
    end
  end
endmodule // smseq_top
